// ===== verilog/cic_defs.svh
// Purpose: offsets, fields, reset values and codes of the cascaded
//          interrupt controller pair
// Assumes: word registers, byte addresses within one 256-byte window
// Notes:   bank bit selects master (0) or slave (1)
`ifndef CIC_DEFS_SVH
`define CIC_DEFS_SVH

// byte address layout: haddr[7:6] zero, haddr[5] bank, haddr[4:2] register
`define CIC_BANK_BIT   5
`define CIC_REG_CTRL   3'h0
`define CIC_REG_BASE   3'h1
`define CIC_REG_MASK   3'h2
`define CIC_REG_CMD    3'h3
`define CIC_REG_PEND   3'h4
`define CIC_REG_INSV   3'h5
`define CIC_REG_POLL   3'h6

// control register fields
`define CIC_CTRL_AUTOMATIC_END_OF_INTERRUPT  0
`define CIC_CTRL_SFNM  1
`define CIC_CTRL_SMM   2

// command register: code in [7:5], line in [2:0]
`define CIC_CMD_NSEOI  3'h1
`define CIC_CMD_SEOI   3'h3
`define CIC_CMD_POLL   3'h4

// reset values
`define CIC_RST_CTRL   3'h0
`define CIC_RST_BASE   8'h20
`define CIC_RST_MASK   8'hff

// master line that carries the internal slave, and the spurious line
`define CIC_SLAVE_LINE 3'h2
`define CIC_SPUR_LINE  3'h7

`endif

// ===== verilog/cic_pkg.sv
// Purpose: types and shared decode functions of the controller pair
// Assumes: line 0 is the highest level, line 7 the lowest
// Notes:   no rotation of levels is modelled
package cic_pkg;

    typedef enum logic [0:0] {ACK_IDLE, ACK_WAIT2} cic_ack_t;

    typedef struct packed {
        logic [7:0] pend;
        logic [7:0] insv;
    } cic_core_st_t;

    typedef struct packed {
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [15:0] sync3;
        logic [15:0] filt;
        logic        s_irq_q;
        logic [2:0]  m_ctrl;
        logic [2:0]  s_ctrl;
        logic [7:0]  m_base;
        logic [7:0]  s_base;
        logic [7:0]  m_mask;
        logic [7:0]  s_mask;
        logic [7:0]  m_poll;
        logic [7:0]  s_poll;
        logic        dp_wr;
        logic        dp_rd;
        logic [7:0]  dp_addr;
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
        cic_ack_t    ack_st;
        logic [2:0]  ack_line;
        logic        ack_slave;
        logic [2:0]  s_line;
        logic        int_request;
        logic [7:0]  ack_vector;
        logic        ack_vector_valid;
        logic [2:0]  cascade_select;
    } cic_top_st_t;

    // highest-level set bit: {found, index}
    function automatic logic [3:0] cic_first(input logic [7:0] bits);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (bits[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    // lines whose level may interrupt the current in-service state
    function automatic logic [7:0] cic_allow(input logic [7:0] insv,
                                             input logic       sfnm,
                                             input logic       smm);
        logic [7:0] r;
        logic [3:0] top;
        top = cic_first(insv);
        r = 8'hff;
        if (smm) begin
            r = ~insv;
        end else if (top[3]) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = (3'(i) < top[2:0]) || (sfnm && 3'(i) == top[2:0]);
            end
        end
        return r;
    endfunction

    // vector of a line: base plus line index
    function automatic logic [7:0] cic_vec(input logic [7:0] base,
                                           input logic [2:0] line);
        return 8'(base + {5'h00, line});
    endfunction

endpackage

// ===== verilog/cic_core.sv
// Purpose: one controller: pending, in-service, priority and takes
// Assumes: request rises arrive already synchronised, one cycle each
// Notes:   outputs depend on state, mask and mode inputs only, so the top may feed back
`timescale 1ns/1ns
`include "cic_defs.svh"
module cic_core (
    input  wire logic       hclk,      // system clock
    input  wire logic       hresetn,   // async reset, low
    input  wire logic       ce,        // clock enable
    input  wire logic [7:0] req_rise,  // new request per line
    input  wire logic [7:0] mask,      // mask bits
    input  wire logic       automatic_end_of_interrupt,      // automatic end of interrupt
    input  wire logic       sfnm,      // special fully nested
    input  wire logic       smm,       // special mask mode
    input  wire logic       do_ack,    // acknowledge best line
    input  wire logic       do_poll,   // poll command
    input  wire logic       eoi_ns,    // nonspecific end of interrupt
    input  wire logic       eoi_sp,    // specific end of interrupt
    input  wire logic [2:0] eoi_line,  // line for specific command
    output logic      [7:0] pend,      // pending bits
    output logic      [7:0] insv,      // in-service bits
    output logic            ack_ok,    // a line may be forwarded
    output logic      [2:0] ack_line,  // line that would be taken
    output logic            poll_ok,   // poll would find a request
    output logic      [2:0] poll_line  // line a poll would take
);
    import cic_pkg::*;

    cic_core_st_t q;
    cic_core_st_t n;
    logic [7:0]   allow;
    logic [3:0]   best_a;
    logic [3:0]   best_p;
    logic [3:0]   top_is;

    // priority resolution from in-service bits and mode
    always_comb begin
        allow  = cic_allow(q.insv, sfnm, smm);
        best_a = cic_first(q.pend & ~mask & allow);
        best_p = cic_first(q.pend & allow);
        top_is = cic_first(q.insv);
    end

    assign pend      = q.pend;
    assign insv      = q.insv;
    assign ack_ok    = best_a[3];
    assign ack_line  = best_a[2:0];
    assign poll_ok   = best_p[3];
    assign poll_line = best_p[2:0];

    // clears first, sets last, so a same-cycle set is never lost
    always_comb begin
        n = q;
        if (eoi_sp) begin
            n.insv[eoi_line] = 1'b0;
        end
        if (eoi_ns && top_is[3]) begin
            n.insv[top_is[2:0]] = 1'b0;
        end
        if (do_ack && best_a[3]) begin
            n.pend[best_a[2:0]] = 1'b0;
            // auto mode ends service at once: any level may preempt
            n.insv[best_a[2:0]] = ~automatic_end_of_interrupt;
        end
        if (do_poll && best_p[3]) begin
            n.pend[best_p[2:0]] = 1'b0;
            n.insv[best_p[2:0]] = 1'b1;
        end
        n.pend = n.pend | req_rise;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else if (ce) begin
            q <= n;
        end
    end
endmodule

// ===== verilog/cic_top.sv
// Purpose: master/slave interrupt controller pair behind AHB-Lite
// Assumes: acknowledge pulses come from logic on hclk; request lines
//          come from pins or other domains and are synchronised
// Notes:   edge-triggered requests only; fixed levels, line 0 highest
`timescale 1ns/1ns
`include "cic_defs.svh"
module cic_top (
    input  wire logic        hclk,              // 20 MHz system clock
    input  wire logic        hresetn,           // async reset, low
    input  wire logic        ce,                // clock enable
    input  wire logic        hsel,              // ahb slave select
    input  wire logic [31:0] haddr,             // ahb address
    input  wire logic [1:0]  htrans,            // ahb transfer type
    input  wire logic        hwrite,            // ahb write
    input  wire logic [2:0]  hsize,             // ahb size, word only
    input  wire logic [31:0] hwdata,            // ahb write data
    input  wire logic        hready,            // ahb bus ready
    output logic      [31:0] hrdata,            // ahb read data
    output logic             hreadyout,         // ahb slave ready
    output logic             hresp,             // ahb response, okay
    input  wire logic [7:0]  m_request_line,    // master lines, 2 unused
    input  wire logic [7:0]  s_request_line,    // slave lines
    input  wire logic        ack_pulse,         // cpu acknowledge pulse
    output logic             int_request,       // request to cpu
    output logic      [7:0]  ack_vector,        // vector on data bus
    output logic             ack_vector_valid,  // vector strobe
    output logic      [2:0]  cascade_select     // answering slave id
);
    import cic_pkg::*;

    localparam cic_top_st_t RST = '{
        m_ctrl: `CIC_RST_CTRL, s_ctrl: `CIC_RST_CTRL,
        m_base: `CIC_RST_BASE, s_base: `CIC_RST_BASE,
        m_mask: `CIC_RST_MASK, s_mask: `CIC_RST_MASK,
        hreadyout: 1'b1, ack_st: ACK_IDLE, default: '0};

    cic_top_st_t q;
    cic_top_st_t n;

    logic [15:0] stable;
    logic [15:0] rise;
    logic [7:0]  m_rise;
    logic        bus_take;
    logic        wr_slave;
    logic [2:0]  wr_reg;
    logic [2:0]  cmd_code;
    logic        m_ack;
    logic        s_ack;
    logic        m_poll;
    logic        s_poll;
    logic        m_ns;
    logic        s_ns;
    logic        m_sp;
    logic        s_sp;
    logic [2:0]  eoi_line;
    logic [7:0]  m_pend;
    logic [7:0]  m_insv;
    logic        m_ack_ok;
    logic [2:0]  m_ack_line;
    logic        m_poll_ok;
    logic [2:0]  m_poll_line;
    logic [7:0]  s_pend;
    logic [7:0]  s_insv;
    logic        s_ack_ok;
    logic [2:0]  s_ack_line;
    logic        s_poll_ok;
    logic [2:0]  s_poll_line;
    logic [2:0]  take_line;
    logic [31:0] rd_word;

    // read multiplexer; unmapped words read zero with an okay answer
    function automatic logic [31:0] read_reg(input logic [2:0] r,
                                             input logic [2:0] ctrl,
                                             input logic [7:0] base,
                                             input logic [7:0] mask,
                                             input logic [7:0] pend,
                                             input logic [7:0] insv,
                                             input logic [7:0] poll);
        logic [7:0] v;
        v = 8'h00;
        unique case (r)
            `CIC_REG_CTRL: v = {5'h00, ctrl};
            `CIC_REG_BASE: v = base;
            `CIC_REG_MASK: v = mask;
            `CIC_REG_PEND: v = pend;
            `CIC_REG_INSV: v = insv;
            `CIC_REG_POLL: v = poll;
            default:       v = 8'h00;
        endcase
        return {24'h00_0000, v};
    endfunction

    // master and slave controllers; slave has no automatic end mode
    cic_core u_master (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .req_rise  (m_rise),
        .mask      (q.m_mask),
        .automatic_end_of_interrupt      (q.m_ctrl[`CIC_CTRL_AUTOMATIC_END_OF_INTERRUPT]),
        .sfnm      (q.m_ctrl[`CIC_CTRL_SFNM]),
        .smm       (q.m_ctrl[`CIC_CTRL_SMM]),
        .do_ack    (m_ack),
        .do_poll   (m_poll),
        .eoi_ns    (m_ns),
        .eoi_sp    (m_sp),
        .eoi_line  (eoi_line),
        .pend      (m_pend),
        .insv      (m_insv),
        .ack_ok    (m_ack_ok),
        .ack_line  (m_ack_line),
        .poll_ok   (m_poll_ok),
        .poll_line (m_poll_line)
    );

    cic_core u_slave (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .req_rise  (rise[15:8]),
        .mask      (q.s_mask),
        .automatic_end_of_interrupt      (1'b0),
        .sfnm      (q.s_ctrl[`CIC_CTRL_SFNM]),
        .smm       (q.s_ctrl[`CIC_CTRL_SMM]),
        .do_ack    (s_ack),
        .do_poll   (s_poll),
        .eoi_ns    (s_ns),
        .eoi_sp    (s_sp),
        .eoi_line  (eoi_line),
        .pend      (s_pend),
        .insv      (s_insv),
        .ack_ok    (s_ack_ok),
        .ack_line  (s_ack_line),
        .poll_ok   (s_poll_ok),
        .poll_line (s_poll_line)
    );

    // request edges: count a rise once stages two and three agree
    always_comb begin
        stable = ~(q.sync2 ^ q.sync3);
        rise   = stable & q.sync2 & ~q.filt;
        // slave forwarding shows up as a rise on master line 2
        m_rise = {rise[7:3], s_ack_ok & ~q.s_irq_q, rise[1:0]};
    end

    // command decode in the write data phase
    always_comb begin
        wr_slave = q.dp_addr[`CIC_BANK_BIT];
        wr_reg   = q.dp_addr[4:2];
        cmd_code = hwdata[7:5];
        eoi_line = hwdata[2:0];
        m_ns   = 1'b0;
        s_ns   = 1'b0;
        m_sp   = 1'b0;
        s_sp   = 1'b0;
        m_poll = 1'b0;
        s_poll = 1'b0;
        if (q.dp_wr && q.dp_addr[7:6] == 2'b00 && wr_reg == `CIC_REG_CMD) begin
            m_ns   = !wr_slave && cmd_code == `CIC_CMD_NSEOI;
            s_ns   = wr_slave && cmd_code == `CIC_CMD_NSEOI;
            m_sp   = !wr_slave && cmd_code == `CIC_CMD_SEOI;
            s_sp   = wr_slave && cmd_code == `CIC_CMD_SEOI;
            m_poll = !wr_slave && cmd_code == `CIC_CMD_POLL;
            s_poll = wr_slave && cmd_code == `CIC_CMD_POLL;
        end
    end

    // first acknowledge pulse takes the master's best line
    always_comb begin
        take_line = m_ack_ok ? m_ack_line : `CIC_SPUR_LINE;
        m_ack = ack_pulse && q.ack_st == ACK_IDLE;
        s_ack = m_ack && m_ack_ok
                && m_ack_line == `CIC_SLAVE_LINE;
    end

    // next state of everything the top owns
    always_comb begin
        n = q;
        bus_take = hsel && hready && htrans[1];
        rd_word  = q.dp_addr[`CIC_BANK_BIT]
            ? read_reg(q.dp_addr[4:2], q.s_ctrl, q.s_base, q.s_mask,
                       s_pend, s_insv, q.s_poll)
            : read_reg(q.dp_addr[4:2], q.m_ctrl, q.m_base, q.m_mask,
                       m_pend, m_insv, q.m_poll);

        // three-stage synchroniser and agreed level
        n.sync1 = {s_request_line, m_request_line};
        n.sync2 = q.sync1;
        n.sync3 = q.sync2;
        n.filt  = (q.filt & ~stable) | (q.sync2 & stable);
        n.s_irq_q = s_ack_ok;

        // address phase; reads get one wait state so that the word
        // sampled already includes a write made just before
        n.dp_wr     = bus_take && hwrite;
        n.dp_rd     = bus_take && !hwrite;
        n.dp_addr   = haddr[7:0];
        n.hreadyout = !(bus_take && !hwrite);
        n.hresp     = 1'b0;
        if (q.dp_rd) begin
            n.hrdata = (q.dp_addr[7:6] == 2'b00) ? rd_word : 32'h0000_0000;
        end

        // register writes in the data phase
        if (q.dp_wr && q.dp_addr[7:6] == 2'b00) begin
            unique case ({wr_slave, wr_reg})
                {1'b0, `CIC_REG_CTRL}: n.m_ctrl = hwdata[2:0];
                {1'b1, `CIC_REG_CTRL}: n.s_ctrl = hwdata[2:0];
                {1'b0, `CIC_REG_BASE}: n.m_base = hwdata[7:0];
                {1'b1, `CIC_REG_BASE}: n.s_base = hwdata[7:0];
                {1'b0, `CIC_REG_MASK}: n.m_mask = hwdata[7:0];
                {1'b1, `CIC_REG_MASK}: n.s_mask = hwdata[7:0];
                default: ;
            endcase
        end

        // poll byte reflects what the poll command took
        if (m_poll) begin
            n.m_poll = {m_poll_ok, 4'h0, m_poll_line};
        end
        if (s_poll) begin
            n.s_poll = {s_poll_ok, 4'h0, s_poll_line};
        end

        // acknowledge handshake over two pulses
        n.int_request      = m_ack_ok;
        n.ack_vector_valid = 1'b0;
        unique case (q.ack_st)
            ACK_IDLE: begin
                if (ack_pulse) begin
                    n.ack_line  = take_line;
                    n.ack_slave = s_ack;
                    n.s_line    = s_ack_ok ? s_ack_line : `CIC_SPUR_LINE;
                    // cascade names the slave hung on the taken line
                    n.cascade_select = take_line;
                    n.ack_st = ACK_WAIT2;
                end
            end
            ACK_WAIT2: begin
                if (ack_pulse) begin
                    n.ack_vector = q.ack_slave
                        ? cic_vec(q.s_base, q.s_line)
                        : cic_vec(q.m_base, q.ack_line);
                    n.ack_vector_valid = 1'b1;
                    n.ack_st = ACK_IDLE;
                end
            end
        endcase
    end

    assign hrdata           = q.hrdata;
    assign hreadyout        = q.hreadyout;
    assign hresp            = q.hresp;
    assign int_request      = q.int_request;
    assign ack_vector       = q.ack_vector;
    assign ack_vector_valid = q.ack_vector_valid;
    assign cascade_select   = q.cascade_select;

    // one register for all state; low enable freezes everything
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= RST;
        end else if (ce) begin
            q <= n;
        end
    end
endmodule

// ===== verification/cic_props.sv
// Purpose: bus and acknowledge timing checks on the controller pair ports
// Assumes: one clock, hready tied to hreadyout, word transfers only
// Notes:   pulse parity is tracked here since the pins carry no phase
`timescale 1ns/1ns
module cic_props (
    input wire logic        hclk,              // system clock
    input wire logic        hresetn,           // async reset, low
    input wire logic        ce,                // clock enable
    input wire logic        hsel,              // slave select
    input wire logic [1:0]  htrans,            // transfer type
    input wire logic        hwrite,            // write
    input wire logic        hready,            // bus ready
    input wire logic [31:0] hrdata,            // read data
    input wire logic        hreadyout,         // slave ready
    input wire logic        hresp,             // response
    input wire logic        ack_pulse,         // acknowledge pulse
    input wire logic [7:0]  ack_vector,        // vector
    input wire logic        ack_vector_valid,  // vector strobe
    input wire logic [2:0]  cascade_select     // answering slave
);
    logic ph;
    logic p1;
    logic p2;
    wire logic take = hsel & hready & htrans[1] & ce;
    // ph high means the next pulse is the second of its pair
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph <= 1'b0;
            p1 <= 1'b0;
            p2 <= 1'b0;
        end else begin
            ph <= ph ^ (ce & ack_pulse);
            p1 <= ce & ack_pulse & ~ph;
            p2 <= ce & ack_pulse & ph;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_always_okay: assert property (hresp == 1'b0)
        else $error("error response driven");
    a_read_one_wait: assert property (take && !hwrite |=>
        !hreadyout ##1 hreadyout) else $error("read wait not one cycle");
    a_write_no_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stretched");
    a_ready_low_once: assert property (!hreadyout |=> hreadyout)
        else $error("hreadyout low too long");
    a_rdata_hold: assert property ($changed(hrdata) |-> $rose(hreadyout))
        else $error("hrdata moved outside read completion");
    a_valid_second: assert property (ack_vector_valid == p2)
        else $error("vector strobe not after second pulse");
    a_vector_hold: assert property ($changed(ack_vector) |->
        ack_vector_valid) else $error("vector changed without strobe");
    a_cascade_first: assert property ($changed(cascade_select) |-> p1)
        else $error("cascade select changed outside first pulse");
    c_read: cover property (take && !hwrite);
    c_vector: cover property (ack_vector_valid);
    c_slave_taken: cover property (p1 && cascade_select == 3'h2);
endmodule

// ===== verification/cic_cpu.sv
// Purpose: cpu side that runs two-pulse acknowledge cycles on request
// Assumes: called right after a rising edge of hclk
// Notes:   gap 0 gives back to back pulses, larger gaps a slow cpu
`timescale 1ns/1ns
module cic_cpu (
    input  wire logic       hclk,              // system clock
    input  wire logic [7:0] ack_vector,        // vector from controller
    input  wire logic       ack_vector_valid,  // vector strobe
    output logic            ack_pulse          // acknowledge pulse
);
    initial ack_pulse = 1'b0;
    // one acknowledge cycle is exactly two pulses; vector x on no answer
    task automatic ack_cycle(input int gap, output logic [7:0] vec);
        int n;
        ack_pulse <= 1'b1;
        @(posedge hclk);
        if (gap > 0) begin
            ack_pulse <= 1'b0;
            repeat (gap) @(posedge hclk);
            ack_pulse <= 1'b1;
        end
        @(posedge hclk);
        ack_pulse <= 1'b0;
        // take the vector at the edge where its strobe is sampled high
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (ack_vector_valid !== 1'b1 && n < 8);
        vec = (ack_vector_valid === 1'b1) ? ack_vector : 8'hxx;
    endtask
endmodule

// ===== verification/cic_top_test.sv
// Purpose: register, acknowledge, cascade, end of interrupt and poll tests
// Assumes: 20 MHz clock, requests are pin rises held a few cycles
// Notes:   expected vectors are worked out from the bases written here
`timescale 1ns/1ns
`include "cic_defs.svh"
module cic_top_test;
    logic        hclk, hresetn, ce, hsel, hwrite;
    logic [31:0] haddr, hwdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  m_req, s_req, v;
    wire logic   hready;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, ack_pulse, int_request, ack_vector_valid;
    logic [7:0]  ack_vector;
    logic [2:0]  cascade_select;
    int          mismatches, tests_run;
    assign hready = hreadyout;
    cic_top DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .m_request_line(m_req),
        .s_request_line(s_req), .ack_pulse(ack_pulse),
        .int_request(int_request), .ack_vector(ack_vector),
        .ack_vector_valid(ack_vector_valid),
        .cascade_select(cascade_select));
    cic_cpu cpu (.hclk(hclk), .ack_vector(ack_vector),
        .ack_vector_valid(ack_vector_valid), .ack_pulse(ack_pulse));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait for hready sampled high at a rising edge
    task automatic wrdy;
        int n;
        n = 0;
        while (hready !== 1'b1 && n < 20) begin
            @(posedge hclk);
            n++;
        end
        if (n == 20) begin
            chk(32'h0000_0000, 32'h0000_0001);
            results();
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        wrdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        wrdy();
        q = hrdata;
    endtask
    function automatic logic [31:0] ra(input logic b, input logic [2:0] r);
        return {24'h00_0000, 2'b00, b, r, 2'b00};
    endfunction
    task automatic wr(input logic b, input logic [2:0] r,
                      input logic [31:0] d);
        xfer(1'b1, ra(b, r), d);
    endtask
    task automatic rc(input logic b, input logic [2:0] r,
                      input logic [31:0] e);
        xfer(1'b0, ra(b, r), 32'h0000_0000);
        chk(q, e);
    endtask
    // a rise held three cycles, then time for sync and forwarding
    task automatic pin(input logic b, input int l);
        if (b) s_req[l] <= 1'b1;
        else m_req[l] <= 1'b1;
        repeat (3) @(posedge hclk);
        s_req <= 8'h00;
        m_req <= 8'h00;
        repeat (8) @(posedge hclk);
    endtask
    initial begin
        repeat (5000) @(posedge hclk);
        mismatches++;
        results();
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {ce, hsize, m_req, s_req, mismatches, tests_run} = {1'b1, 3'h2, 80'h0};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int b = 0; b < 2; b++) begin
            rc(1'(b), `CIC_REG_CTRL, 32'h0000_0000);
            rc(1'(b), `CIC_REG_BASE, 32'h0000_0020);
            rc(1'(b), `CIC_REG_MASK, 32'h0000_00ff);
            rc(1'(b), `CIC_REG_PEND, 32'h0000_0000);
            rc(1'(b), `CIC_REG_INSV, 32'h0000_0000);
            rc(1'(b), `CIC_REG_POLL, 32'h0000_0000);
            rc(1'(b), `CIC_REG_CMD, 32'h0000_0000);
            rc(1'(b), 3'h7, 32'h0000_0000);
        end
        xfer(1'b1, 32'h0000_0044, 32'h0000_0088);
        rc(0, `CIC_REG_BASE, 32'h0000_0020);
        $display("test reset values done");
        pin(0, 5);
        rc(0, `CIC_REG_PEND, 32'h0000_0020);
        chk(32'(int_request), 32'h0000_0000);
        wr(0, `CIC_REG_BASE, 32'h0000_0040);
        wr(0, `CIC_REG_MASK, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        chk(32'(int_request), 32'h0000_0001);
        cpu.ack_cycle(3, v);
        chk(32'(v), 32'h0000_0045);
        chk(32'(cascade_select), 32'h0000_0005);
        rc(0, `CIC_REG_PEND, 32'h0000_0000);
        rc(0, `CIC_REG_INSV, 32'h0000_0020);
        $display("test master acknowledge done");
        pin(0, 6);
        chk(32'(int_request), 32'h0000_0000);
        pin(0, 3);
        chk(32'(int_request), 32'h0000_0001);
        cpu.ack_cycle(0, v);
        chk(32'(v), 32'h0000_0043);
        rc(0, `CIC_REG_INSV, 32'h0000_0028);
        wr(0, `CIC_REG_CMD, 32'h0000_0020);
        rc(0, `CIC_REG_INSV, 32'h0000_0020);
        chk(32'(int_request), 32'h0000_0000);
        wr(0, `CIC_REG_CMD, 32'h0000_0065);
        rc(0, `CIC_REG_INSV, 32'h0000_0000);
        chk(32'(int_request), 32'h0000_0001);
        cpu.ack_cycle(1, v);
        chk(32'(v), 32'h0000_0046);
        wr(0, `CIC_REG_CMD, 32'h0000_0066);
        rc(0, `CIC_REG_INSV, 32'h0000_0000);
        $display("test nesting and end commands done");
        wr(1, `CIC_REG_BASE, 32'h0000_0070);
        wr(1, `CIC_REG_MASK, 32'h0000_0000);
        pin(1, 4);
        rc(0, `CIC_REG_PEND, 32'h0000_0004);
        chk(32'(int_request), 32'h0000_0001);
        cpu.ack_cycle(2, v);
        chk(32'(v), 32'h0000_0074);
        chk(32'(cascade_select), 32'h0000_0002);
        rc(0, `CIC_REG_INSV, 32'h0000_0004);
        rc(1, `CIC_REG_INSV, 32'h0000_0010);
        rc(1, `CIC_REG_PEND, 32'h0000_0000);
        wr(1, `CIC_REG_CMD, 32'h0000_0064);
        wr(0, `CIC_REG_CMD, 32'h0000_0020);
        rc(0, `CIC_REG_INSV, 32'h0000_0000);
        $display("test cascade done");
        wr(0, `CIC_REG_CTRL, 32'h0000_0001);
        pin(0, 1);
        cpu.ack_cycle(1, v);
        chk(32'(v), 32'h0000_0041);
        rc(0, `CIC_REG_INSV, 32'h0000_0000);
        wr(0, `CIC_REG_CTRL, 32'h0000_0000);
        $display("test automatic end done");
        wr(0, `CIC_REG_MASK, 32'h0000_00ff);
        pin(0, 7);
        pin(0, 4);
        chk(32'(int_request), 32'h0000_0000);
        wr(0, `CIC_REG_CMD, 32'h0000_0080);
        rc(0, `CIC_REG_POLL, 32'h0000_0084);
        rc(0, `CIC_REG_INSV, 32'h0000_0010);
        wr(0, `CIC_REG_CMD, 32'h0000_0020);
        wr(0, `CIC_REG_CMD, 32'h0000_0080);
        rc(0, `CIC_REG_POLL, 32'h0000_0087);
        wr(0, `CIC_REG_CMD, 32'h0000_0020);
        wr(0, `CIC_REG_CMD, 32'h0000_0080);
        rc(0, `CIC_REG_POLL, 32'h0000_0000);
        $display("test poll done");
        wr(0, `CIC_REG_MASK, 32'h0000_0000);
        wr(0, `CIC_REG_CTRL, 32'h0000_0004);
        pin(0, 1);
        cpu.ack_cycle(0, v);
        pin(0, 6);
        chk(32'(int_request), 32'h0000_0001);
        cpu.ack_cycle(0, v);
        chk(32'(v), 32'h0000_0046);
        wr(0, `CIC_REG_CMD, 32'h0000_0066);
        rc(0, `CIC_REG_INSV, 32'h0000_0002);
        wr(0, `CIC_REG_CTRL, 32'h0000_0002);
        pin(0, 1);
        chk(32'(int_request), 32'h0000_0001);
        $display("test special modes done");
        results();
    end
endmodule
bind cic_top cic_props u_props (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ack_pulse(ack_pulse), .ack_vector(ack_vector),
    .ack_vector_valid(ack_vector_valid), .cascade_select(cascade_select));
